// [rtl/rcsp_device.sv]
// Operation
// - Device is only the serial slave
// - Registers and buffer share one framing
// - Bytes shift most significant bit first
// - Header: read, burst, six-bit address
// - Host keeps select low whole transaction
// - Select high mid-transfer aborts it
// - Host waits for low serial output
// - Ready low only when oscillator stable
// - Awake device drives ready low immediately
// - Reset strobe restores defined state
// - Configuration registers reset to defaults
// - Host rewrites non-default registers after reset
// - Logic runs from crystal oscillator clock
// - Sixty-four byte transmit buffer
// - Status byte: ready flag, free count
// - Status bits six-four give main state
// - Configuration at addresses 0x00-0x2E
module rcsp_device
  import rcsp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  rcsp_if.dev link,
  input wire logic osc_stable,
  input wire logic osc_off_state,
  input wire logic [2:0] main_state,
  input wire logic tx_pop,
  output logic [7:0] tx_data,
  output logic tx_empty,
  output logic [5:0] tx_level,
  output logic [7:0] cfg_probe,
  input wire logic [5:0] cfg_probe_addr
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Two flops on every pin; only the second stage feeds any logic
  logic [1:0] cs_s, sck_s, si_s;
  // Delayed clock level for edge finding, taken from the second stage
  logic sck_d;
  always_ff @(posedge mclk) begin
    cs_s <= {cs_s[0], link.chip_select_n};
    sck_s <= {sck_s[0], link.sclk};
    si_s <= {si_s[0], link.si};
    sck_d <= sck_s[1];
  end
  wire cs_act = !cs_s[1];
  wire sck_rise = sck_s[1] && !sck_d;
  wire sck_fall = !sck_s[1] && sck_d;
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] cfg_mem [CFG_COUNT];
  logic [7:0] buf_mem [TXBUF_DEPTH];
  logic [5:0] wr_ptr_reg, rd_ptr_reg;
  logic [6:0] count_reg;
  logic soft_rst_reg;
  wire any_rst = rst || soft_rst_reg;
  // ---------------------------------------------------------------
  // Frame shifter
  // ---------------------------------------------------------------
  logic [2:0] bit_cnt_reg;
  logic [7:0] sh_in_reg, sh_out_reg;
  logic hdr_seen_reg, rd_reg, burst_reg, so_reg, oe_n_reg;
  logic [5:0] addr_reg;
  logic byte_done;
  wire [7:0] rx_byte = {sh_in_reg[6:0], si_s[1]};
  // Data byte heading for a configuration register or the buffer
  wire wr_byte = byte_done && hdr_seen_reg && !rd_reg;
  wire push = wr_byte && addr_reg == TXBUF_ADDR && count_reg != 7'(TXBUF_DEPTH);
  // The byte taken at this edge already counts in the next status byte
  wire [6:0] count_now = count_reg + 7'(push);
  // Free count saturates: fifteen means fifteen or more
  wire [3:0] free_sat = (count_now <= 7'(TXBUF_DEPTH - 15)) ? FREE_SAT :
    4'(7'(TXBUF_DEPTH) - count_now);
  wire [7:0] status_byte = {!osc_stable, main_state, free_sat};
  assign byte_done = cs_act && sck_rise && (bit_cnt_reg == 3'h7);
  // Read data for the byte after this one; at the header edge the decoded
  // fields are not in their registers yet, so they are taken from the shifter
  wire rd_next = hdr_seen_reg ? rd_reg : rx_byte[HDR_RW_BIT];
  // Burst reads step to the following address, as the decode below does
  wire [5:0] rd_addr = hdr_seen_reg ?
    addr_reg + 6'(burst_reg && addr_reg < CFG_LAST_ADDR) : rx_byte[ADDR_W-1:0];
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr <= CFG_LAST_ADDR) begin
      rd_data = cfg_mem[rd_addr];
    end
  end
  // Bit counter and input shift; sampling on SCLK rise
  always_ff @(posedge mclk) begin
    if (rst || !cs_act) begin
      bit_cnt_reg <= 3'h0;
      sh_in_reg <= 8'h00;
      hdr_seen_reg <= 1'b0;
    end else if (sck_rise) begin
      sh_in_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        hdr_seen_reg <= 1'b1;
      end
    end
  end
  // Header decode
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_reg <= 1'b0;
      burst_reg <= 1'b0;
      addr_reg <= 6'h00;
    end else if (byte_done && !hdr_seen_reg) begin
      rd_reg <= rx_byte[HDR_RW_BIT];
      burst_reg <= rx_byte[HDR_BURST_BIT];
      addr_reg <= rx_byte[ADDR_W-1:0];
    end else if (byte_done && burst_reg && addr_reg < CFG_LAST_ADDR) begin
      // Burst walks the configuration space
      addr_reg <= addr_reg + 6'h1;
    end
  end
  // Output shifter; changes on SCLK fall so the host samples on rise
  always_ff @(posedge mclk) begin
    // Released pin rests high, so a host never mistakes it for ready
    if (rst || !cs_act) begin
      so_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      sh_out_reg <= 8'h00;
    end else begin
      oe_n_reg <= 1'b0;
      if (bit_cnt_reg == 3'h0 && !sck_s[1] && !hdr_seen_reg) begin
        so_reg <= !osc_stable || osc_off_state;
        sh_out_reg <= {status_byte[6:0], 1'b0};
      end else if (byte_done) begin
        // Next byte: read data, or status while writing
        // Only read frames return data; all else returns status
        sh_out_reg <= rd_next ? rd_data : status_byte;
      end else if (sck_fall) begin
        if (bit_cnt_reg == 3'h0) begin
          so_reg <= sh_out_reg[7];
          sh_out_reg <= {sh_out_reg[6:0], 1'b0};
        end else begin
          so_reg <= sh_out_reg[7];
          sh_out_reg <= {sh_out_reg[6:0], 1'b0};
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Writes: configuration, transmit buffer, reset strobe
  // ---------------------------------------------------------------
  wire strobe_hit = byte_done && !hdr_seen_reg && rx_byte[ADDR_W-1:0] == RESET_STROBE_ADDR
    && !rx_byte[HDR_BURST_BIT];
  always_ff @(posedge mclk) begin
    soft_rst_reg <= !rst && strobe_hit;
  end
  always_ff @(posedge mclk) begin
    for (int i = 0; i < CFG_COUNT; i++) begin
      if (any_rst) begin
        cfg_mem[i] <= CFG_RESET_VAL;
      end else if (wr_byte && addr_reg == 6'(i)) begin
        cfg_mem[i] <= rx_byte;
      end
    end
  end
  // transmit buffer
  // A full buffer drops further bytes; the host reads the free count first
  wire pop = tx_pop && count_reg != 7'h00;
  always_ff @(posedge mclk) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= rx_byte;
    end
  end
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count_reg <= 7'h00;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + 6'(push);
      rd_ptr_reg <= rd_ptr_reg + 6'(pop);
      count_reg <= count_reg + 7'(push) - 7'(pop);
    end
  end
  // Registered user outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_data <= 8'h00;
      tx_empty <= 1'b1;
      tx_level <= 6'h00;
      cfg_probe <= 8'h00;
    end else begin
      tx_data <= buf_mem[rd_ptr_reg];
      tx_empty <= count_reg == 7'h00;
      tx_level <= count_reg[5:0];
      cfg_probe <= (cfg_probe_addr <= CFG_LAST_ADDR) ? cfg_mem[cfg_probe_addr] : 8'h00;
    end
  end
  assign link.so = so_reg;
  assign link.so_oe_n = oe_n_reg;
endmodule

// [rtl/rcsp_host.sv]
// Host master: software starts one byte exchange per DATA write
module rcsp_host
  import rcsp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  rcsp_if.host link,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic sel_reg;             // CTRL bit0: hold chip select low
  logic [7:0] tx_reg, rx_reg;
  logic [1:0] stat_reg, mask_reg; // bit0 byte done, bit1 ready seen
  logic [7:0] div_reg;
  logic busy_reg, ack_reg;
  logic cs_n_reg, sck_reg, si_reg;
  logic [1:0] so_s, oe_s; // Serial output and its enable, two flops each
  logic frame_rdy_reg; // Ready level seen since select fell
  rcsp_hstate_t st_reg;
  logic [7:0] div_cnt_reg;
  logic [3:0] edge_cnt_reg;
  logic [7:0] sh_reg;
  logic ev_done, ev_rdy;
  wire tick = div_cnt_reg == 8'h00;
  wire acc = (avs_read || avs_write) && !ack_reg;
  // Transfer completes at the edge where waitrequest is low
  wire commit = ack_reg && (avs_read || avs_write);
  // Synchronise serial output
  always_ff @(posedge mclk) begin
    so_s <= {so_s[0], link.so};
    oe_s <= {oe_s[0], link.so_oe_n};
  end
  // ready seen once per frame; the event feeds status bit1
  always_ff @(posedge mclk) begin
    if (rst || cs_n_reg) begin
      frame_rdy_reg <= 1'b0;
      ev_rdy <= 1'b0;
    end else begin
      frame_rdy_reg <= frame_rdy_reg || (!so_s[1] && !oe_s[1]);
      ev_rdy <= !frame_rdy_reg && !so_s[1] && !oe_s[1];
    end
  end
  // ---------------------------------------------------------------
  // Avalon slave: one wait cycle then answer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      sel_reg <= 1'b0;
      mask_reg <= 2'h0;
      div_reg <= SCLK_DIV_RESET;
    end else begin
      ack_reg <= acc;
      avs_waitrequest <= !acc;
      if (acc && avs_read) begin
        unique case (avs_address)
          REG_CTRL: avs_readdata <= {30'h0, busy_reg, sel_reg};
          REG_RESULT: avs_readdata <= {24'h0, rx_reg};
          REG_DATA: avs_readdata <= {24'h0, tx_reg};
          REG_IRQ_STAT: avs_readdata <= {30'h0, stat_reg};
          REG_IRQ_MASK: avs_readdata <= {30'h0, mask_reg};
          REG_SCLK_DIV: avs_readdata <= {24'h0, div_reg};
          default: avs_readdata <= UNMAPPED_VAL;
        endcase
      end
      if (commit && avs_write) begin
        if (avs_address == REG_CTRL) sel_reg <= avs_writedata[0];
        if (avs_address == REG_IRQ_MASK) mask_reg <= avs_writedata[1:0];
        if (avs_address == REG_SCLK_DIV) div_reg <= avs_writedata[7:0];
      end
    end
  end
  // Sticky status; set wins over clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_reg <= 2'h0;
    end else begin
      stat_reg <= (stat_reg & ~((commit && avs_write && avs_address == REG_IRQ_STAT) ?
        avs_writedata[1:0] : 2'h0)) | {ev_rdy, ev_done};
    end
  end
  always_ff @(posedge mclk) begin
    irq <= !rst && |(stat_reg & mask_reg);
  end
  // ---------------------------------------------------------------
  // Byte engine, SCLK from divider
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || tick) div_cnt_reg <= div_reg;
    else div_cnt_reg <= div_cnt_reg - 8'h1;
  end
  wire start = commit && avs_write && avs_address == REG_DATA;
  always_ff @(posedge mclk) begin
    ev_done <= 1'b0;
    if (rst) begin
      st_reg <= RCSP_H_IDLE;
      busy_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      si_reg <= 1'b0;
      tx_reg <= 8'h0;
      rx_reg <= 8'h0;
      sh_reg <= 8'h0;
      edge_cnt_reg <= 4'h0;
    end else begin
      if (!busy_reg) cs_n_reg <= !sel_reg;
      unique case (st_reg)
        RCSP_H_IDLE: if (start && !busy_reg) begin
          tx_reg <= avs_writedata[7:0];
          sh_reg <= avs_writedata[7:0];
          busy_reg <= 1'b1;
          cs_n_reg <= 1'b0;
          st_reg <= RCSP_H_WAIT_RDY;
        end
        // wait ready low
        // Later bytes of a frame start at once: their first bit is data
        RCSP_H_WAIT_RDY: if (frame_rdy_reg && tick) begin
          edge_cnt_reg <= 4'h0;
          si_reg <= sh_reg[7];
          st_reg <= RCSP_H_SHIFT;
        end
        RCSP_H_SHIFT: if (tick) begin
          sck_reg <= !sck_reg;
          edge_cnt_reg <= edge_cnt_reg + 4'h1;
          if (!sck_reg) begin
            sh_reg <= {sh_reg[6:0], so_s[1]};
          end else if (edge_cnt_reg == 4'hf) begin
            st_reg <= RCSP_H_DONE;
          end else begin
            si_reg <= sh_reg[7];
          end
        end
        RCSP_H_DONE: begin
          rx_reg <= sh_reg;
          busy_reg <= 1'b0;
          ev_done <= 1'b1;
          st_reg <= RCSP_H_IDLE;
        end
        default: st_reg <= RCSP_H_IDLE;
      endcase
      // Software dropping select cuts the byte short
      if (busy_reg && !sel_reg) begin
        st_reg <= RCSP_H_IDLE;
        busy_reg <= 1'b0;
        cs_n_reg <= 1'b1;
        sck_reg <= 1'b0;
      end
    end
  end
  assign link.chip_select_n = cs_n_reg;
  assign link.sclk = sck_reg;
  assign link.si = si_reg;
endmodule

// [rtl/rcsp_if.sv]
// Four-wire serial link between host and radio device
interface rcsp_if;
  logic chip_select_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe_n;
  modport host (output chip_select_n, output sclk, output si, input so, input so_oe_n);
  modport dev (input chip_select_n, input sclk, input si, output so, output so_oe_n);
endinterface

// [rtl/rcsp_pkg.sv]
package rcsp_pkg;
  // ---------------------------------------------------------------
  // Header byte layout
  // ---------------------------------------------------------------
  localparam int HDR_RW_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam int ADDR_W = 6;
  // ---------------------------------------------------------------
  // Device map
  // ---------------------------------------------------------------
  localparam logic [5:0] CFG_LAST_ADDR = 6'h2e;
  localparam logic [5:0] TXBUF_ADDR = 6'h3f;
  localparam logic [5:0] RESET_STROBE_ADDR = 6'h30;
  localparam int CFG_COUNT = 47;
  localparam int TXBUF_DEPTH = 64;
  localparam logic [7:0] CFG_RESET_VAL = 8'h00;
  // ---------------------------------------------------------------
  // Status byte fields and main states
  // ---------------------------------------------------------------
  localparam int ST_READY_BIT = 7;
  localparam logic [3:0] FREE_SAT = 4'hf;
  localparam logic [2:0] ST_IDLE = 3'h0;
  localparam logic [2:0] ST_TX = 3'h2;
  localparam logic [2:0] ST_FSTX = 3'h3;
  localparam logic [2:0] ST_CAL = 3'h4;
  localparam logic [2:0] ST_SETTLE = 3'h5;
  localparam logic [2:0] ST_UNDERFLOW = 3'h7;
  // ---------------------------------------------------------------
  // Host register map (Avalon word byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_DATA = 5'h04;
  localparam logic [4:0] REG_RESULT = 5'h08;
  localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
  localparam logic [4:0] REG_IRQ_MASK = 5'h10;
  localparam logic [4:0] REG_SCLK_DIV = 5'h14;
  localparam logic [7:0] SCLK_DIV_RESET = 8'h06;
  localparam logic [31:0] UNMAPPED_VAL = 32'hdeadbeef;
  // Host sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    RCSP_H_IDLE = 3'b000,
    RCSP_H_WAIT_RDY = 3'b001,
    RCSP_H_SHIFT = 3'b011,
    RCSP_H_DONE = 3'b010
  } rcsp_hstate_t;
endpackage

// [verification/rcsp_properties.sv]
// Watches the four-wire link between host and device ends
module rcsp_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rdy_seen_reg; // Ready level seen in this frame
  logic rise_seen_reg; // Clock already rose in this frame
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Frame trackers, cleared while deselected
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || chip_select_n) begin
      rdy_seen_reg <= 1'b0;
    end else if (!so_oe_n && !so) begin
      rdy_seen_reg <= 1'b1;
    end
  end
  // Marks the first clock rise of a frame
  always_ff @(posedge mclk) begin
    if (rst || chip_select_n) begin
      rise_seen_reg <= 1'b0;
    end else if ($rose(sclk)) begin
      rise_seen_reg <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  AST_OE_ONLY_SELECTED:
    assert property (chip_select_n [*5] |-> so_oe_n) else $error("so driven while deselected");
  AST_OE_RELEASE:
    assert property ($rose(chip_select_n) |-> ##[1:4] so_oe_n) else $error("so not released");
  AST_HOST_WAITS:
    assert property (!chip_select_n && !rdy_seen_reg |-> !$rose(sclk))
    else $error("clock before ready");
  AST_NO_EDGE_IDLE:
    assert property (chip_select_n |-> !$rose(sclk)) else $error("clock edge while deselected");
  AST_SI_STABLE:
    assert property (!chip_select_n && $rose(sclk) |-> $stable(si)) else $error("si moved at rise");
  AST_SO_STABLE:
    assert property (!so_oe_n && $rose(sclk) |-> $stable(so)) else $error("so moved at rise");
  AST_SCLK_HIGH:
    assert property ($rose(sclk) |-> (sclk || chip_select_n) [*7]) else $error("clock high short");
  AST_READY_FIRST_BIT:
    assert property ($rose(sclk) && !chip_select_n && !rise_seen_reg |-> !so_oe_n && !so)
    else $error("first status bit not ready");
endmodule

// [verification/tb_top.sv]
module tb_top;
  import rcsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0] st;
    logic [5:0] a;
    logic [7:0] v;
  } rcsp_row_t;
  logic mclk, rst, osc_stable, osc_off_state, tx_pop, tx_empty, irq;
  logic [2:0] main_state;
  logic [5:0] cfg_probe_addr, tx_level;
  logic [7:0] tx_data, cfg_probe, r;
  logic avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int n_fail, samples_checked;
  // One row per main state: state, register, value
  rcsp_row_t rows [6] = '{'{ST_IDLE, 6'h00, 8'h81}, '{ST_TX, 6'h2e, 8'h3c},
    '{ST_FSTX, 6'h01, 8'ha5}, '{ST_CAL, 6'h10, 8'h7e}, '{ST_SETTLE, 6'h20, 8'h01},
    '{ST_UNDERFLOW, 6'h2d, 8'hf0}};
  rcsp_if link_if ();
  rcsp_device rcsp_device_inst (.mclk(mclk), .rst(rst), .link(link_if), .osc_stable(osc_stable),
    .osc_off_state(osc_off_state), .main_state(main_state), .tx_pop(tx_pop), .tx_data(tx_data),
    .tx_empty(tx_empty), .tx_level(tx_level), .cfg_probe(cfg_probe),
    .cfg_probe_addr(cfg_probe_addr));
  rcsp_host rcsp_host_inst (.mclk(mclk), .rst(rst), .link(link_if), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  rcsp_properties rcsp_properties_inst (.mclk(mclk), .rst(rst),
    .chip_select_n(link_if.chip_select_n), .sclk(link_if.sclk), .si(link_if.si),
    .so(link_if.so), .so_oe_n(link_if.so_oe_n));
  // ---------------------------------------------------------------
  // Clock, compare, verdict
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Expected status byte: ready, state, free count saturated
  function automatic logic [7:0] stat(input logic [2:0] s, input int free);
    return {1'b0, s, (free > 15) ? FREE_SAT : 4'(free)};
  endfunction
  // ---------------------------------------------------------------
  // Bus tasks; the extra edge keeps back-to-back strobes apart
  // ---------------------------------------------------------------
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) n_fail++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // One byte exchange; the returned byte lands in r
  task automatic xfer(input logic [7:0] b);
    int n;
    n = 0;
    av(1'b1, REG_DATA, {24'h0, b});
    do begin
      av(1'b0, REG_IRQ_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b1 && n < 200);
    if (q[0] !== 1'b1) n_fail++;
    av(1'b0, REG_RESULT, 32'h0);
    r = q[7:0];
    av(1'b1, REG_IRQ_STAT, 32'h1);
  endtask
  task automatic sel(input logic on);
    av(1'b1, REG_CTRL, {31'h0, on});
  endtask
  task automatic probe(input logic [5:0] a, output logic [7:0] v);
    cfg_probe_addr <= a;
    repeat (3) @(posedge mclk);
    v = cfg_probe;
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge mclk);
    check(32'(irq), 32'(v));
  endtask
  // Watchdog: the whole run needs well under this span
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    osc_stable = 1'b1;
    osc_off_state = 1'b0;
    main_state = ST_IDLE;
    tx_pop = 1'b0;
    cfg_probe_addr = 6'h00;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_fail = 0;
    samples_checked = 0;
    // Three edges so the link synchronisers clear too
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      main_state <= rows[i].st;
      sel(1'b1);
      xfer({2'b00, rows[i].a});
      check(32'(r), 32'(stat(rows[i].st, 64)));
      xfer(rows[i].v);
      check(32'(r), 32'(stat(rows[i].st, 64)));
      sel(1'b0);
      probe(rows[i].a, r);
      check(32'(r), 32'(rows[i].v));
      sel(1'b1);
      xfer({2'b10, rows[i].a});
      xfer(8'h00);
      check(32'(r), 32'(rows[i].v));
      sel(1'b0);
    end
    // Mid-run reset brings every register back to default
    main_state <= ST_IDLE;
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      probe(rows[i].a, r);
      check(32'(r), 32'(CFG_RESET_VAL));
    end
    // Buffer burst: free count falls through the saturation point
    sel(1'b1);
    xfer({2'b01, TXBUF_ADDR});
    for (int k = 0; k < 60; k++) begin
      xfer(8'(k * 5 + 3));
      check(32'(r), 32'(stat(ST_IDLE, 64 - k)));
    end
    sel(1'b0);
    check(32'(tx_level), 32'd60);
    check(32'(tx_data), 32'h03);
    tx_pop <= 1'b1;
    @(posedge mclk);
    tx_pop <= 1'b0;
    repeat (3) @(posedge mclk);
    check(32'(tx_data), 32'h08);
    check(32'({tx_empty, tx_level}), 32'd59);
    // Burst configuration write walks up the addresses
    sel(1'b1);
    xfer({2'b01, 6'h05});
    xfer(8'h11);
    xfer(8'h22);
    sel(1'b0);
    probe(6'h06, r);
    check(32'(r), 32'h22);
    // Select dropped mid-byte: the write must not land
    sel(1'b1);
    xfer({2'b00, 6'h01});
    av(1'b1, REG_DATA, 32'h5a);
    repeat (40) @(posedge mclk);
    sel(1'b0);
    probe(6'h01, r);
    check(32'(r), 32'(CFG_RESET_VAL));
    // Ready withheld until the oscillator is stable
    av(1'b1, REG_IRQ_STAT, 32'h3);
    av(1'b1, REG_IRQ_MASK, 32'h2);
    osc_stable <= 1'b0;
    sel(1'b1);
    repeat (30) @(posedge mclk);
    check(32'(link_if.so_oe_n | link_if.so), 32'h1);
    irq_is(1'b0);
    // Oscillator-off state withholds ready as well
    osc_off_state <= 1'b1;
    osc_stable <= 1'b1;
    repeat (20) @(posedge mclk);
    check(32'(link_if.so_oe_n | link_if.so), 32'h1);
    osc_off_state <= 1'b0;
    osc_stable <= 1'b1;
    repeat (20) @(posedge mclk);
    check(32'({link_if.so_oe_n, link_if.so}), 32'h0);
    irq_is(1'b1);
    av(1'b1, REG_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    av(1'b1, REG_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    sel(1'b0);
    av(1'b1, REG_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    // Reset strobe clears what the burst wrote
    sel(1'b1);
    xfer({2'b00, RESET_STROBE_ADDR});
    sel(1'b0);
    probe(6'h05, r);
    check(32'(r), 32'(CFG_RESET_VAL));
    av(1'b0, REG_SCLK_DIV, 32'h0);
    check(q, 32'(SCLK_DIV_RESET));
    av(1'b0, 5'h1c, 32'h0);
    check(q, UNMAPPED_VAL);
    complete_run();
  end
endmodule
